// File: bench/alu_model.sv
// stand-in alu feeding result, carry, half carry and overflow
// assumes plain 8-bit add or subtract of two operands
`timescale 1ns/10ps
module alu_model (
  // operands
  input  wire logic       sub_in,
  input  wire logic [7:0] a_in,
  input  wire logic [7:0] b_in,
  // alu status
  output logic [7:0]      result_out,
  output logic            carry_out,
  output logic            half_out,
  output logic            ovf_out
);
  // nine bit sum or difference, borrow lands in the top bit
  assign {carry_out, result_out} = sub_in ? {1'b0, a_in} - {1'b0, b_in}
                                          : {1'b0, a_in} + {1'b0, b_in};
  // low nibble carry out of bit 3 or borrow
  assign half_out = sub_in ? (a_in[3:0] < b_in[3:0])
                  : ({1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} > 5'h0F);
  // signed range exit
  assign ovf_out = (a_in[7] ^ result_out[7]) & ~(a_in[7] ^ b_in[7] ^ sub_in);
endmodule // alu_model

// File: bench/cpu_condition_flags_props.sv
// assertions on the ports of the condition flag block
// assumes binding into cpu_condition_flags, one clock domain
`timescale 1ns/10ps
module cpu_condition_flags_props (
  // clock and reset
  input wire logic                              clk_in,
  input wire logic                              resetn_in,
  // decoder side
  input wire cpu_condition_flags_pkg::flag_op_t op_in,
  input wire logic                              sub_in,
  input wire logic [7:0]                        result_in,
  input wire logic                              carry_in,
  input wire logic                              half_in,
  input wire logic                              ovf_in,
  input wire logic                              shift_out_in,
  input wire logic                              bit_in,
  input wire logic                              reg_wr_in,
  // watched outputs
  input wire logic                              irq_block_out,
  input wire logic                              fast_return_out,
  input wire logic                              bank_sel_out,
  input wire logic [7:0]                        flags_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // op class decodes and result msb
  wire ar = op_in == cpu_condition_flags_pkg::op_arith;
  wire lg = op_in == cpu_condition_flags_pkg::op_logic;
  wire sh = op_in == cpu_condition_flags_pkg::op_shift;
  wire r7 = result_in[7];
  a_carry_arith: assert property (ar |=> flags_out[7] == $past(carry_in))
    else $error("carry wrong after add");
  a_shift_carry: assert property (sh |=> flags_out[7] == $past(shift_out_in))
    else $error("carry wrong after shift");
  a_carry_invert: assert property (op_in == cpu_condition_flags_pkg::op_cpl_c
    |=> flags_out == ($past(flags_out) ^ 8'h80)) else $error("carry invert");
  a_zero_result: assert property (ar || lg
    |=> flags_out[6] == ($past(result_in) == 8'h00)) else $error("zero flag");
  a_bit_zero: assert property (op_in == cpu_condition_flags_pkg::op_bit
    |=> flags_out[6] == !$past(bit_in)) else $error("bit test zero");
  a_sign_msb: assert property (ar || lg || sh |=> flags_out[5] == $past(r7))
    else $error("sign flag");
  a_ovf_arith: assert property (ar |=> flags_out[4] == $past(ovf_in))
    else $error("overflow flag");
  a_logic_ovf: assert property (lg |=> !flags_out[4])
    else $error("overflow after logic");
  a_dec_half: assert property (ar
    |=> flags_out[3:2] == {$past(sub_in), $past(half_in)}) else $error("d or h");
  a_fast_ro: assert property (reg_wr_in && op_in == cpu_condition_flags_pkg::op_none
    |=> $stable(flags_out[1])) else $error("fast bit written");
  a_fast_return: assert property (fast_return_out == (flags_out[1] &&
    op_in == cpu_condition_flags_pkg::op_interrupt_return_op)) else $error("fast return");
  a_irq_block: assert property (irq_block_out == flags_out[1])
    else $error("irq block");
  a_bank_one: assert property (op_in == cpu_condition_flags_pkg::op_bank1
    |=> bank_sel_out && flags_out[0]) else $error("bank one");
endmodule // cpu_condition_flags_props
bind cpu_condition_flags cpu_condition_flags_props u_cpu_condition_flags_props (.*);

// File: bench/testbench.sv
// self-checking bench for the condition flag block
// assumes alu_model and the bound checker are compiled first
`timescale 1ns/10ps
module testbench;
  logic        clk_in = 1'b0, resetn_in = 1'b0, sub_in = 1'b0;
  logic        shift_out_in = 1'b0, bit_in = 1'b0, reg_wr_in = 1'b0;
  logic [7:0]  a = 8'h00, b = 8'h00, f = 8'h00, x;
  logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
  logic [3:0]  cond_in = 4'h0;
  logic [7:0]  result_in, reg_rdata_out, dadj_result_out, flags_out;
  logic        carry_in, half_in, ovf_in, jump_take_out;
  logic        irq_block_out, fast_return_out, bank_sel_out;
  logic [15:0] lfsr = 16'h8CF0, e, q[$];
  logic [25:0] d;
  logic [25:0] dt [3] = '{{8'h15, 8'h27, 1'b0, 8'h42, 1'b0},
    {8'h99, 8'h01, 1'b0, 8'h00, 1'b1}, {8'h42, 8'h15, 1'b1, 8'h27, 1'b0}};
  int          num_errors = 0, samples_checked = 0, cyc = 0;
  cpu_condition_flags_pkg::flag_op_t op_in = cpu_condition_flags_pkg::op_none;
  // clock, design and alu stand-in
  always #50 clk_in = ~clk_in;
  cpu_condition_flags u_cpu_condition_flags (.*);
  alu_model u_alu_model (.sub_in(sub_in), .a_in(a), .b_in(b),
    .result_out(result_in), .carry_out(carry_in), .half_out(half_in),
    .ovf_out(ovf_in));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // apply one op at the falling edge, note the masked flags after it
  task automatic go(input logic [3:0] o, input logic w, input logic [7:0] xv,
    input logic [7:0] y, input logic s, input logic [7:0] m, input logic [7:0] v);
    @(negedge clk_in);
    op_in = cpu_condition_flags_pkg::flag_op_t'(o);
    reg_wr_in = w;
    a = xv;
    b = y;
    reg_wdata_in = xv;
    reg_addr_in = y;
    {sub_in, shift_out_in, bit_in} = {3{s}};
    #1;
    if (o == 4'h1)
      v = {carry_in, result_in == 8'h00, result_in[7], ovf_in, s, half_in, f[1:0]};
    f = (f & ~m) | (v & m);
    q.push_back({m, v & m});
  endtask
  // load flags, then walk every condition code
  task automatic jt(input logic [7:0] v, input logic [15:0] p);
    go(4'h0, 1'b1, v, 8'hD5, 1'b0, 8'hFF, v & 8'hFD);
    for (int c = 0; c < 16; c++) begin
      @(negedge clk_in);
      cond_in = c[3:0];
      #1;
      chk({7'h00, jump_take_out}, {7'h00, p[c]});
    end
  endtask
  task automatic summarize();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // settled flags and read data against the oldest note
  always @(posedge clk_in) begin
    #1;
    if (q.size() > 0) begin
      e = q.pop_front();
      chk(flags_out & e[15:8], e[7:0]);
      chk(reg_rdata_out & e[15:8], e[7:0]);
    end
  end
  // hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    resetn_in = 1'b1;
    go(4'h0, 1'b0, 8'h00, 8'h00, 1'b0, 8'hFF, 8'h00);
    // random sums and differences, signed overflow corner first
    for (int i = 0; i < 24; i++) begin
      lfsr = nxt(lfsr);
      go(4'h1, 1'b0, i ? lfsr[7:0] : 8'h80, i ? lfsr[15:8] : 8'h80, lfsr[0],
        8'hFF, 8'h00);
    end
    // logic, shift and bit test back to back
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      x = i[0] ? lfsr[7:0] : 8'h00;
      go(4'h2, 1'b0, x, 8'h00, 1'b0, 8'h70, {1'b0, x == 8'h00, x[7], 5'h00});
      go(4'h3, 1'b0, x, 8'h00, lfsr[9], 8'hE0, {lfsr[9], x == 8'h00, x[7], 5'h00});
      go(4'h4, 1'b0, x, 8'h00, lfsr[10], 8'h40, {1'b0, !lfsr[10], 6'h00});
    end
    $display("test flag updates done");
    // carry and bank ops leave the other bits alone
    go(4'h0, 1'b1, 8'h5A, 8'hD5, 1'b0, 8'hFF, 8'h58);
    go(4'h5, 1'b0, 8'h00, 8'h00, 1'b0, 8'hFF, f | 8'h80);
    go(4'h6, 1'b0, 8'h00, 8'h00, 1'b0, 8'hFF, f & 8'h7F);
    go(4'h7, 1'b0, 8'h00, 8'h00, 1'b0, 8'hFF, f ^ 8'h80);
    go(4'h7, 1'b0, 8'h00, 8'h00, 1'b0, 8'hFF, f ^ 8'h80);
    go(4'hA, 1'b0, 8'h00, 8'h00, 1'b0, 8'hFF, f | 8'h01);
    go(4'h9, 1'b0, 8'h00, 8'h00, 1'b0, 8'hFF, f & 8'hFE);
    go(4'h0, 1'b1, 8'hFF, 8'hD4, 1'b0, 8'hFF, f);
    go(4'h0, 1'b1, 8'hFF, 8'hD5, 1'b0, 8'hFF, 8'hFD);
    // fast service entry, work inside it, return
    go(4'h0, 1'b1, 8'h35, 8'hD5, 1'b0, 8'hFF, 8'h35);
    go(4'hB, 1'b0, 8'h00, 8'h00, 1'b0, 8'hFF, 8'h37);
    go(4'h1, 1'b0, 8'h01, 8'h01, 1'b0, 8'hFF, 8'h00);
    go(4'h0, 1'b1, 8'h00, 8'hD5, 1'b0, 8'hFF, 8'h02);
    go(4'hB, 1'b0, 8'h00, 8'h00, 1'b0, 8'hFF, 8'h02);
    go(4'hC, 1'b0, 8'h00, 8'h00, 1'b0, 8'hFF, 8'h35);
    go(4'hC, 1'b0, 8'h00, 8'h00, 1'b0, 8'hFF, 8'h35);
    $display("test carry bank fast done");
    // decimal adjust after add and subtract
    for (int i = 0; i < 3; i++) begin
      d = dt[i];
      go(4'h1, 1'b0, d[25:18], d[17:10], d[9], 8'hFF, 8'h00);
      go(4'h8, 1'b0, d[25:18], d[17:10], d[9], 8'hE0,
        {d[0], d[8:1] == 8'h00, d[8], 5'h00});
      chk(dadj_result_out, d[8:1]);
    end
    jt(8'h0C, 16'hFF00);
    jt(8'h90, 16'h619E);
    $display("test adjust and jumps done");
    repeat (2) @(negedge clk_in);
    summarize();
  end
endmodule // testbench

// File: pkg/bcd_if.sv
// carries operands and results between the flag block and its bcd helper
// assumes one clock domain; purely combinational traffic
`timescale 1ns/10ps
interface bcd_if;
  logic [7:0] value;
  logic       carry;
  logic       half;
  logic       was_sub;
  logic [7:0] fixed;
  logic       carry_out;
  modport owner  (output value, carry, half, was_sub,
                  input fixed, carry_out);
  modport helper (input value, carry, half, was_sub,
                  output fixed, carry_out);
endinterface

// File: pkg/cpu_condition_flags_params.svh
// constants for the condition flag block
// assumes inclusion by bare name from rtl files
`ifndef CPU_CONDITION_FLAGS_PARAMS_SVH
`define CPU_CONDITION_FLAGS_PARAMS_SVH
`define FLAGS_ADDR      8'hD5
`define FLAG_CARRY      7
`define FLAG_ZERO       6
`define FLAG_SIGN       5
`define FLAG_OVF        4
`define FLAG_DEC        3
`define FLAG_HALF       2
`define FLAG_FAST       1
`define FLAG_BANK       0
`define FLAGS_RESET     8'h00
`define BYTE_ZERO       8'h00
`define BCD_LOW_FIX     8'h06
`define BCD_HIGH_FIX    8'h60
`define BCD_BOTH_FIX    8'h66
`define NIB_LIMIT       4'h9
`define BYTE_LIMIT      8'h99
`define BYTE_MSB        7
`define NIB_MSB         3
`endif

// File: pkg/cpu_condition_flags_pkg.sv
// types for the condition flag block
// assumes nothing of its surroundings
package cpu_condition_flags_pkg;
  typedef enum logic [3:0] {
    op_none   = 4'h0,
    op_arith  = 4'h1,
    op_logic  = 4'h2,
    op_shift  = 4'h3,
    op_bit    = 4'h4,
    op_set_c  = 4'h5,
    op_clr_c  = 4'h6,
    op_cpl_c  = 4'h7,
    op_dadj   = 4'h8,
    op_bank0  = 4'h9,
    op_bank1  = 4'hA,
    op_fast   = 4'hB,
    op_interrupt_return_op   = 4'hC
  } flag_op_t;

  typedef enum logic [1:0] {
    svc_idle  = 2'b00,
    svc_fast  = 2'b01
  } svc_state_t;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] shadow;
    svc_state_t svc;
  } flag_state_t;
endpackage

// File: rtl/bcd_adjust.sv
// decimal adjust correction of a prior binary add or subtract
// assumes the owner supplies the carry, half carry and add/sub record
`timescale 1ns/10ps
`include "cpu_condition_flags_params.svh"
module bcd_adjust (
  // link to flag block
  bcd_if.helper b
);
  logic lo_fix;
  logic hi_fix;
  logic [7:0] corr;

  // pick correction from carry, half carry and operation kind
  always_comb begin
    lo_fix = b.half || (!b.was_sub && (b.value[3:0] > `NIB_LIMIT));
    hi_fix = b.carry || (!b.was_sub && (b.value > `BYTE_LIMIT));
    corr   = `BYTE_ZERO;
    if (lo_fix && hi_fix) begin
      corr = `BCD_BOTH_FIX;
    end else if (lo_fix) begin
      corr = `BCD_LOW_FIX;
    end else if (hi_fix) begin
      corr = `BCD_HIGH_FIX;
    end
    b.fixed     = b.was_sub ? b.value - corr : b.value + corr; // RULE11
    b.carry_out = hi_fix;
  end
endmodule // bcd_adjust

// File: rtl/cpu_condition_flags.sv
// condition flag register of an 8-bit cpu with jump evaluation
// assumes decoder drives op_in for one cycle per executed instruction
// Functional notes
// RULE1 - carry set on msb carry or borrow
// RULE2 - shifts load carry with last bit out
// RULE3 - set, clear, invert carry alone
// RULE4 - zero flag from arithmetic/logic result
// RULE5 - zero flag for bit tests and shifts
// RULE6 - sign flag copies result msb
// RULE7 - overflow flag on signed range exit
// RULE8 - logic operations clear overflow
// RULE9 - decimal flag records add or subtract
// RULE10 - half carry from bit 3/4
// RULE11 - decimal adjust uses h, c, d
// RULE12 - fast flag set on entry, cleared on return
// RULE13 - fast flag blocks interrupts, selects fast return
// RULE14 - bank flag follows bank select ops
// RULE15 - jumps test only upper four flags
// RULE16 - colliding flag writes give undefined value; here the flag op wins over the register write
// RULE17 - non-flag instructions may write flags
// RULE18 - bits numbered seven down to zero
// RULE19 - shadow saved on fast entry, restored
// RULE20 - flags update with result writeback
`timescale 1ns/10ps
`include "cpu_condition_flags_params.svh"
module cpu_condition_flags (
  // clock and reset
  input  wire logic                              clk_in,
  input  wire logic                              resetn_in,
  // decoder side
  input  wire cpu_condition_flags_pkg::flag_op_t op_in,
  input  wire logic                              sub_in,
  input  wire logic [7:0]                        result_in,
  input  wire logic                              carry_in,
  input  wire logic                              half_in,
  input  wire logic                              ovf_in,
  input  wire logic                              shift_out_in,
  input  wire logic                              bit_in,
  // register file access
  input  wire logic [7:0]                        reg_addr_in,
  input  wire logic                              reg_wr_in,
  input  wire logic [7:0]                        reg_wdata_in,
  output logic [7:0]                             reg_rdata_out,
  // decimal adjust result
  output logic [7:0]                             dadj_result_out,
  // jump evaluation
  input  wire logic [3:0]                        cond_in,
  output logic                                   jump_take_out,
  // interrupt control, bank select and flag register outputs
  output logic                                   irq_block_out,
  output logic                                   fast_return_out,
  output logic                                   bank_sel_out,
  output logic [7:0]                             flags_out
);
  cpu_condition_flags_pkg::flag_state_t st_r;
  cpu_condition_flags_pkg::flag_state_t st_nxt;
  bcd_if bcd ();
  logic sw_hit;

  // zero test used by several ops
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == `BYTE_ZERO);
  endfunction

  // decimal adjust helper
  bcd_adjust u_bcd (
    .b (bcd.helper)
  );

  // feed helper with last binary result and bcd flags
  assign bcd.value   = result_in;
  assign bcd.carry   = st_r.flags[`FLAG_CARRY]; // RULE11
  assign bcd.half    = st_r.flags[`FLAG_HALF];
  assign bcd.was_sub = st_r.flags[`FLAG_DEC];

  // condition code evaluation
  jump_condition u_jmp (
    .flags_in (st_r.flags),
    .cond_in  (cond_in),
    .take_out (jump_take_out)
  );

  assign sw_hit = reg_wr_in && (reg_addr_in == `FLAGS_ADDR);

  // next state; all flags land in the writeback cycle
  always_comb begin
    st_nxt = st_r; // RULE20
    // plain writes from loads; fast bit stays read only
    if (sw_hit) begin
      st_nxt.flags[7:2] = reg_wdata_in[7:2]; // RULE17
      st_nxt.flags[`FLAG_BANK] = reg_wdata_in[`FLAG_BANK];
    end
    // a flag update on the same cycle overrides the register write for the bits it touches
    unique case (op_in) // RULE16
      cpu_condition_flags_pkg::op_none: begin
      end
      cpu_condition_flags_pkg::op_arith: begin
        st_nxt.flags[`FLAG_CARRY] = carry_in; // RULE1
        st_nxt.flags[`FLAG_ZERO]  = is_zero(result_in); // RULE4
        st_nxt.flags[`FLAG_SIGN]  = result_in[`BYTE_MSB]; // RULE6
        st_nxt.flags[`FLAG_OVF]   = ovf_in; // RULE7
        st_nxt.flags[`FLAG_DEC]   = sub_in; // RULE9
        st_nxt.flags[`FLAG_HALF]  = half_in; // RULE10
      end
      cpu_condition_flags_pkg::op_logic: begin
        st_nxt.flags[`FLAG_ZERO] = is_zero(result_in); // RULE4
        st_nxt.flags[`FLAG_SIGN] = result_in[`BYTE_MSB]; // RULE6
        st_nxt.flags[`FLAG_OVF]  = 1'b0; // RULE8
      end
      cpu_condition_flags_pkg::op_shift: begin
        st_nxt.flags[`FLAG_CARRY] = shift_out_in; // RULE2
        st_nxt.flags[`FLAG_ZERO]  = is_zero(result_in); // RULE5
        st_nxt.flags[`FLAG_SIGN]  = result_in[`BYTE_MSB]; // RULE6
        st_nxt.flags[`FLAG_OVF]   = ovf_in; // RULE7
      end
      cpu_condition_flags_pkg::op_bit: begin
        st_nxt.flags[`FLAG_ZERO] = !bit_in; // RULE5
      end
      cpu_condition_flags_pkg::op_set_c: begin
        st_nxt.flags[`FLAG_CARRY] = 1'b1; // RULE3
      end
      cpu_condition_flags_pkg::op_clr_c: begin
        st_nxt.flags[`FLAG_CARRY] = 1'b0; // RULE3
      end
      cpu_condition_flags_pkg::op_cpl_c: begin
        st_nxt.flags[`FLAG_CARRY] = !st_r.flags[`FLAG_CARRY]; // RULE3
      end
      cpu_condition_flags_pkg::op_dadj: begin
        st_nxt.flags[`FLAG_CARRY] = bcd.carry_out; // RULE11
        st_nxt.flags[`FLAG_ZERO]  = is_zero(bcd.fixed);
        st_nxt.flags[`FLAG_SIGN]  = bcd.fixed[`BYTE_MSB];
      end
      cpu_condition_flags_pkg::op_bank0: begin
        st_nxt.flags[`FLAG_BANK] = 1'b0; // RULE14
      end
      cpu_condition_flags_pkg::op_bank1: begin
        st_nxt.flags[`FLAG_BANK] = 1'b1; // RULE14
      end
      cpu_condition_flags_pkg::op_fast: begin
        if (st_r.svc == cpu_condition_flags_pkg::svc_idle) begin
          st_nxt.shadow = st_r.flags; // RULE19
          st_nxt.flags[`FLAG_FAST] = 1'b1; // RULE12
          st_nxt.svc = cpu_condition_flags_pkg::svc_fast;
        end
      end
      cpu_condition_flags_pkg::op_interrupt_return_op: begin
        if (st_r.svc == cpu_condition_flags_pkg::svc_fast) begin
          st_nxt.flags = st_r.shadow; // RULE19
          st_nxt.flags[`FLAG_FAST] = 1'b0; // RULE12
          st_nxt.svc = cpu_condition_flags_pkg::svc_idle;
        end
      end
      default: begin
      end
    endcase
  end

  // state register; reset clears bank and fast bits
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '{flags: `FLAGS_RESET, shadow: `FLAGS_RESET,
                svc: cpu_condition_flags_pkg::svc_idle};
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs; bit 7 is msb throughout
  assign flags_out       = st_r.flags; // RULE18
  assign reg_rdata_out   = st_r.flags;
  assign dadj_result_out = bcd.fixed;
  assign bank_sel_out    = st_r.flags[`FLAG_BANK];
  assign irq_block_out   = st_r.flags[`FLAG_FAST]; // RULE13
  assign fast_return_out = st_r.flags[`FLAG_FAST] &&
                           (op_in == cpu_condition_flags_pkg::op_interrupt_return_op);
endmodule // cpu_condition_flags

// File: rtl/jump_condition.sv
// evaluates a four bit condition code from the upper flags only
// assumes flags come from the flag register
`timescale 1ns/10ps
`include "cpu_condition_flags_params.svh"
module jump_condition (
  // flags and code
  input  wire logic [7:0] flags_in,
  input  wire logic [3:0] cond_in,
  // verdict
  output logic            take_out
);
  logic c;
  logic z;
  logic s;
  logic v;
  logic t;

  // only bits 7..4 take part; bcd bits are never tested
  always_comb begin
    c = flags_in[`FLAG_CARRY]; // RULE15
    z = flags_in[`FLAG_ZERO];
    s = flags_in[`FLAG_SIGN];
    v = flags_in[`FLAG_OVF];
    unique case (cond_in[2:0])
      3'h0: t = 1'b0;
      3'h1: t = s ^ v;
      3'h2: t = z | (s ^ v);
      3'h3: t = c | z;
      3'h4: t = v;
      3'h5: t = s;
      3'h6: t = z;
      3'h7: t = c;
    endcase
    take_out = t ^ cond_in[3];
  end
endmodule // jump_condition
